// >>> bench/serial_memory_read_path_assertions.sv
// Purpose: link checks on the two-wire read path
// Assumes: all signals sampled on core_clk_i; scl comes from a host register
// Notes:   bit slots are found by counting scl falls since the last start
`timescale 1ns/1ps
module mem_rd_link_checker (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic scl,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic sda
);
   logic [7:0] nfall;
   logic scl_q;
   logic sda_q;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   ////////////////////////////////////////
   // a start clears the count, so the ninth fall opens the address ack slot
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         nfall <= 8'h00;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (scl && scl_q && sda_q && !sda) begin
            nfall <= 8'h00;
         end else if (scl_q && !scl && nfall != 8'hFF) begin
            nfall <= nfall + 8'h01; // saturates so a long read never aliases slot 9
         end
      end
   end
   sequence s_stop;
      scl && $past(scl) && $rose(sda);
   endsequence
   sequence s_ack_high;
      $rose(scl) && nfall == 8'h09;
   endsequence
   ////////////////////////////////////////
   a_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
      else $error("device drives data high");
   a_host_open_drain: assert property (host_sda_oe |-> !host_sda_o)
      else $error("host drives data high");
   a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
      else $error("device data changed while clock high");
   a_addr_quiet: assert property (nfall inside {[1:8]} |-> !dev_sda_oe)
      else $error("device drives during address byte");
   a_addr_ack_soon: assert property ($fell(scl) && nfall == 8'h08
      |-> ##[1:4] dev_sda_oe)
      else $error("address not acknowledged");
   a_ack_holds: assert property (s_ack_high |-> !sda [*8])
      else $error("ack not low while clock high");
   a_stop_quiet: assert property (s_stop |-> !dev_sda_oe [*8])
      else $error("device drives after stop");
   a_no_clash: assert property (scl |-> !(host_sda_oe && dev_sda_oe))
      else $error("both ends pull data with clock high");
endmodule

// >>> bench/serial_memory_read_path_tb_top.sv
// Purpose: reads through host and device joined by the link
// Assumes: inputs change on the falling edge; memory preloaded by the load port
// Notes:   one stalled read fills the two-entry buffer before draining it
`timescale 1ns/1ps
module serial_memory_read_path_tb_top;
   import mem_rd_pkg::*;
   logic clk = 0, rst_n = 0, vld = 0, sel = 0, rdy = 0, ld = 0, nk_seen = 0;
   logic rdy_o, rv, nk, bsy, act;
   logic [2:0] pg = '0;
   logic [7:0] wa = '0, cnt = '0, ld_d = '0, rd_data;
   logic [1:0] trm = '0;
   logic [10:0] la = '0, cur;
   int bad_count = 0, cmp_count = 0, cyc = 0;
   two_wire_if link ();
   mem_rd_host mem_rd_host_inst (.core_clk_i(clk), .reset_n_i(rst_n), .link(link),
      .cmd_valid_i(vld), .cmd_ready_o(rdy_o), .cmd_selective_i(sel), .cmd_page_i(pg),
      .cmd_addr_i(wa), .cmd_count_i(cnt), .cmd_term_i(trm), .rd_data_o(rd_data),
      .rd_valid_o(rv), .rd_ready_i(rdy), .nack_o(nk), .busy_o(bsy));
   mem_rd_device mem_rd_device_inst (.core_clk_i(clk), .reset_n_i(rst_n), .link(link),
      .load_en_i(ld), .load_addr_i(la), .load_data_i(ld_d), .cur_addr_o(cur),
      .active_o(act));
   mem_rd_link_checker mem_rd_link_checker_inst (.core_clk_i(clk), .reset_n_i(rst_n),
      .scl(link.scl), .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
      .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));
   ////////////////////////////////////////
   // content depends on page bits too, so a wrong page shows as wrong data
   function automatic logic [7:0] pat(input logic [10:0] a);
      return a[7:0] + {a[10:8], 5'h13};
   endfunction
   task automatic chk(input logic [10:0] g, input logic [10:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic end_sim();
      if (bad_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // one command, then pop n bytes; st delays the first pop so the buffer fills
   task automatic rd(input logic s, input logic [2:0] p, input logic [7:0] a, input int n,
                     input logic [1:0] t, input logic st, input logic [10:0] b);
      int i;
      while (rdy_o !== 1'b1) @(negedge clk);
      {sel, pg, wa, cnt, trm, vld} = {s, p, a, 8'(n), t, 1'b1};
      @(negedge clk);
      vld = 0;
      // a selective read needs about 5700 cycles to reach the third byte's
      // eighth bit, so this wait is long enough for the full buffer to stall scl
      if (st) begin
         repeat (6000) @(negedge clk);
         chk({10'h0, link.scl}, 11'h001);
      end
      for (i = 0; i < n; i++) begin
         while (rv !== 1'b1) @(negedge clk);
         chk({3'h0, rd_data}, {3'h0, pat(b + 11'(i))});
         rdy = 1;
         @(negedge clk);
         rdy = 0;
         // let one edge pass with ready low before the next pop
         @(negedge clk);
      end
      while (bsy !== 1'b0) @(negedge clk);
      chk(cur, b + 11'(n));
      chk({10'h0, act}, 11'h000);
   endtask
   ////////////////////////////////////////
   initial begin
      forever #12.5 clk = ~clk;
   end
   // a hang ends the run as a mismatch
   always @(posedge clk) begin
      cyc++;
      if (nk === 1'b1) nk_seen = 1;
      if (cyc == 60000) begin
         bad_count++;
         end_sim();
      end
   end
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1;
      chk(cur, 11'h000);
      for (int k = 0; k < MEM_DEPTH; k++) begin
         {ld, la, ld_d} = {1'b1, 11'(k), pat(11'(k))};
         @(negedge clk);
      end
      ld = 0;
      rd(1, 3'h7, 8'hFF, 3, TERM_NACK_STOP, 1, 11'h7FF);
      rd(0, 3'h0, 8'h00, 2, TERM_NACK_START, 0, 11'h002);
      rd(0, 3'h2, 8'h00, 1, TERM_STOP, 0, 11'h204);
      rd(1, 3'h1, 8'h3C, 2, TERM_START, 0, 11'h13C);
      chk({10'h0, nk_seen}, 11'h000);
      end_sim();
   end
endmodule

// >>> rtl/mem_rd_device.sv
// Purpose: memory end of the two-wire read path, 2048 bytes, read side only
// Assumes: scl and sda are synchronous to core_clk_i; memory filled via load port
// Notes:   write data after the word address is not stored; the device waits
//          for the next start or stop
// Function
// - read bit one in address requests read
// - page bits select the memory block
// - start address is page over latch low byte
// - current read starts at the latch value
// - data driven from clock after address ack
// - address increments after every byte read
// - host ack brings the next sequential byte
// - host ends with nack then stop
// - host may end with nack then start
// - host may stop in ninth clock
// - host may start in ninth clock
// - without proper end device keeps driving data
// - address wraps from 7FF to 000
// - selective read loads word address into latch
// - repeated start abandons write, reads loaded address
// - address byte: page bits 3-1, rw bit 0
// - every byte moves most significant bit first
// - low in ninth clock acks, released ends
// - start anywhere aborts and rearms the device
`timescale 1ns/1ps
module mem_rd_device (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   two_wire_if.dev link,
   input wire logic load_en_i,
   input wire logic [mem_rd_pkg::ADDR_W-1:0] load_addr_i,
   input wire logic [7:0] load_data_i,
   output logic [mem_rd_pkg::ADDR_W-1:0] cur_addr_o,
   output logic active_o
);
   import mem_rd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // all state of the bus engine in one record
   typedef struct packed {
      dev_state_t state;
      logic scl_q;
      logic sda_q;
      logic [3:0] bit_cnt;
      logic [7:0] shreg;
      logic [ADDR_W-1:0] addr;
      logic rw;
      logic sda_oe;
      logic host_ack;
   } dev_regs_t;

   localparam dev_regs_t DEV_RESET = '{
      state: D_IDLE,
      scl_q: 1'b1,
      sda_q: 1'b1,
      bit_cnt: 4'h0,
      shreg: 8'h00,
      addr: ADDR_WRAP,
      rw: RW_WRITE,
      sda_oe: 1'b0,
      host_ack: 1'b0
   };

   dev_regs_t r;
   dev_regs_t next_r;
   logic [7:0] mem [MEM_DEPTH];
   logic [7:0] rd_byte;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   ////////////////////////////////////////////////////////////////////////////////
   // storage: the load port stands in for the write path, which lives elsewhere
   always_ff @(posedge core_clk_i) begin
      if (load_en_i) begin
         mem[load_addr_i] <= load_data_i;
      end
   end

   // the eleven-bit latch addresses the array directly
   assign rd_byte = mem[r.addr];

   ////////////////////////////////////////////////////////////////////////////////
   // bus conditions, judged against the previous sample of both lines
   assign scl_rise = link.scl && !r.scl_q;
   assign scl_fall = !link.scl && r.scl_q;
   // sda moving while scl stays high is a start or a stop, never data
   assign start_seen = link.scl && r.scl_q && r.sda_q && !link.sda;
   assign stop_seen = link.scl && r.scl_q && !r.sda_q && link.sda;

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic of the read engine
   always_comb begin
      next_r = r;
      next_r.scl_q = link.scl;
      next_r.sda_q = link.sda;
      if (start_seen) begin
         // abort whatever runs and wait for a fresh slave address
         next_r.state = D_SLA;
         next_r.bit_cnt = 4'h0;
         next_r.sda_oe = 1'b0;
      end else if (stop_seen) begin
         next_r.state = D_IDLE;
         next_r.bit_cnt = 4'h0;
         next_r.sda_oe = 1'b0;
      end else begin
         unique case (r.state)
            D_IDLE: begin
               next_r.sda_oe = 1'b0;
            end
            D_SLA: begin
               // shift in on the rising edge, most significant bit first
               if (scl_rise) begin
                  next_r.shreg = {r.shreg[6:0], link.sda};
                  next_r.bit_cnt = r.bit_cnt + BIT_ONE;
               end
               if (scl_fall && r.bit_cnt == BIT_ACK) begin
                  next_r.bit_cnt = 4'h0;
                  if (r.shreg[7:4] == DEV_TYPE) begin
                     next_r.state = D_SLA_ACK;
                     next_r.sda_oe = 1'b1;
                     next_r.rw = r.shreg[0];
                     // page bits sit above the low byte already in the latch
                     next_r.addr[10:8] = r.shreg[3:1];
                  end else begin
                     next_r.state = D_IDLE; // stays released for other parts
                  end
               end
            end
            D_SLA_ACK: begin
               // end of the ack clock: release, then either read or take an address
               if (scl_fall) begin
                  next_r.sda_oe = 1'b0;
                  next_r.bit_cnt = 4'h0;
                  if (r.rw == RW_READ) begin
                     next_r.state = D_RD;
                     next_r.shreg = rd_byte;
                     next_r.sda_oe = !rd_byte[7];
                  end else begin
                     next_r.state = D_WADDR;
                  end
               end
            end
            D_WADDR: begin
               if (scl_rise) begin
                  next_r.shreg = {r.shreg[6:0], link.sda};
                  next_r.bit_cnt = r.bit_cnt + BIT_ONE;
               end
               if (scl_fall && r.bit_cnt == BIT_ACK) begin
                  next_r.addr[7:0] = r.shreg;
                  next_r.state = D_WADDR_ACK;
                  next_r.sda_oe = 1'b1;
                  next_r.bit_cnt = 4'h0;
               end
            end
            D_WADDR_ACK: begin
               // after the ack the host is expected to issue a repeated start
               if (scl_fall) begin
                  next_r.sda_oe = 1'b0;
                  next_r.state = D_WIGNORE;
               end
            end
            D_WIGNORE: begin
               next_r.sda_oe = 1'b0;
            end
            D_RD: begin
               // data only changes after scl has gone low, so it never looks
               // like a start or stop to the host
               if (scl_fall) begin
                  if (r.bit_cnt == BIT_LAST) begin
                     next_r.sda_oe = 1'b0; // hand the line to the host for ack
                     next_r.state = D_RD_ACK;
                     // step just before the ack, wrapping at the top
                     next_r.addr = (r.addr == ADDR_MAX) ? ADDR_WRAP
                                 : r.addr + ADDR_STEP;
                  end else begin
                     next_r.bit_cnt = r.bit_cnt + BIT_ONE;
                     next_r.shreg = {r.shreg[6:0], 1'b0};
                     next_r.sda_oe = !r.shreg[6];
                  end
               end
            end
            D_RD_ACK: begin
               if (scl_rise) begin
                  next_r.host_ack = !link.sda;
               end
               if (scl_fall) begin
                  next_r.bit_cnt = 4'h0;
                  if (r.host_ack) begin
                     // an ack always fetches more; a host that then stops
                     // fights the first data bit on the line
                     next_r.state = D_RD;
                     next_r.shreg = rd_byte;
                     next_r.sda_oe = !rd_byte[7];
                  end else begin
                     next_r.state = D_IDLE;
                  end
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r <= DEV_RESET;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs: the pin only ever pulls low
   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe = r.sda_oe;
   assign cur_addr_o = r.addr;
   assign active_o = (r.state != D_IDLE);

endmodule

// >>> rtl/mem_rd_host.sv
// Purpose: bus master end that reads bytes from the two-wire memory
// Assumes: one command at a time; the host alone makes scl by counting core clocks
// Notes:   a full read buffer holds scl high before the ack, so no byte is lost
`timescale 1ns/1ps
module mem_rd_host (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   two_wire_if.host link,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic cmd_selective_i,
   input wire logic [mem_rd_pkg::PAGE_W-1:0] cmd_page_i,
   input wire logic [7:0] cmd_addr_i,
   input wire logic [7:0] cmd_count_i,
   input wire logic [1:0] cmd_term_i,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic nack_o,
   output logic busy_o
);
   import mem_rd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      host_state_t state;
      host_stage_t stage;
      logic [5:0] timer;
      logic scl;
      logic sda_oe;
      logic [7:0] tx;
      logic [7:0] rx;
      logic [3:0] bit_cnt;
      logic [7:0] remaining;
      logic [PAGE_W-1:0] page;
      logic [7:0] waddr;
      logic [1:0] term;
      logic end_after_start;
      logic nack;
      logic [1:0][7:0] buf_data;
      logic wp;
      logic rp;
      logic [1:0] buf_cnt;
   } host_regs_t;

   localparam host_regs_t HOST_RESET = '{
      state: M_IDLE, stage: S_SLA_R, timer: 6'h00, scl: 1'b1, sda_oe: 1'b0,
      tx: 8'h00, rx: 8'h00, bit_cnt: 4'h0, remaining: 8'h00, page: 3'h0,
      waddr: 8'h00, term: TERM_NACK_STOP, end_after_start: 1'b0, nack: 1'b0,
      buf_data: 16'h0000, wp: 1'b0, rp: 1'b0, buf_cnt: 2'h0
   };

   host_regs_t r;
   host_regs_t next_r;
   logic tdone;
   logic last_byte;
   logic push;
   logic pop;
   logic [7:0] rx_full;

   assign tdone = (r.timer == PHASE_LAST);
   assign last_byte = (r.remaining <= 8'h01);
   assign rx_full = {r.rx[6:0], link.sda};
   assign pop = rd_ready_i && (r.buf_cnt != 2'h0);

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer: every bus phase lasts one timer period, except a bit high that a full buffer holds
   always_comb begin
      next_r = r;
      next_r.nack = 1'b0;
      next_r.timer = tdone ? 6'h00 : r.timer + 6'h01;
      push = 1'b0;
      unique case (r.state)
         M_IDLE: begin
            next_r.timer = 6'h00;
            next_r.scl = 1'b1;
            next_r.sda_oe = 1'b0;
            if (cmd_valid_i) begin
               next_r.state = M_START;
               next_r.sda_oe = 1'b1; // sda falls while scl is high
               next_r.page = cmd_page_i;
               next_r.waddr = cmd_addr_i;
               next_r.term = cmd_term_i;
               next_r.end_after_start = 1'b0;
               next_r.remaining = (cmd_count_i == 8'h00) ? 8'h01 : cmd_count_i;
               next_r.stage = cmd_selective_i ? S_SLA_W : S_SLA_R;
               next_r.tx = {DEV_TYPE, cmd_page_i,
                            cmd_selective_i ? RW_WRITE : RW_READ};
            end
         end
         M_START: begin
            if (tdone) begin
               next_r.scl = 1'b0;
               if (r.end_after_start) begin
                  next_r.state = M_STOP_HI; // start then stop, read is over
                  next_r.scl = 1'b1;
               end else begin
                  next_r.state = M_BIT_LO;
                  next_r.bit_cnt = 4'h0;
                  next_r.sda_oe = !r.tx[7];
               end
            end
         end
         M_BIT_LO: begin
            if (tdone) begin
               next_r.scl = 1'b1;
               next_r.state = M_BIT_HI;
            end
         end
         M_BIT_HI: begin
            if (tdone && r.stage == S_READ && r.bit_cnt == BIT_LAST
                && r.buf_cnt == 2'h2) begin
               next_r.timer = r.timer; // buffer full: hold scl high
            end else if (tdone) begin
               next_r.scl = 1'b0;
               next_r.rx = rx_full;
               if (r.bit_cnt != BIT_ACK) begin
                  next_r.bit_cnt = r.bit_cnt + BIT_ONE;
                  next_r.tx = {r.tx[6:0], 1'b0};
                  next_r.state = M_BIT_LO;
                  if (r.stage != S_READ) begin
                     next_r.sda_oe = (r.bit_cnt == BIT_LAST) ? 1'b0 : !r.tx[6];
                  end else if (r.bit_cnt == BIT_LAST) begin
                     push = 1'b1;
                     next_r.sda_oe = !last_byte;
                     if (last_byte && r.term == TERM_STOP) begin
                        next_r.state = M_STOP_LO;
                        next_r.sda_oe = 1'b1;
                     end else if (last_byte && r.term == TERM_START) begin
                        next_r.state = M_RS_LO;
                        next_r.end_after_start = 1'b1;
                     end
                  end else begin
                     next_r.sda_oe = 1'b0;
                  end
               end else begin
                  // end of the ninth clock
                  next_r.bit_cnt = 4'h0;
                  next_r.state = M_STOP_LO;
                  next_r.sda_oe = 1'b1;
                  unique case (r.stage)
                     S_SLA_W: begin
                        if (!link.sda) begin
                           next_r.stage = S_WADDR;
                           next_r.tx = r.waddr;
                           next_r.sda_oe = !r.waddr[7];
                           next_r.state = M_BIT_LO;
                        end else begin
                           next_r.nack = 1'b1;
                        end
                     end
                     S_WADDR: begin
                        if (!link.sda) begin
                           next_r.state = M_RS_LO;
                           next_r.sda_oe = 1'b0;
                        end else begin
                           next_r.nack = 1'b1;
                        end
                     end
                     S_SLA_R: begin
                        if (!link.sda) begin
                           next_r.stage = S_READ;
                           next_r.sda_oe = 1'b0;
                           next_r.state = M_BIT_LO;
                        end else begin
                           next_r.nack = 1'b1;
                        end
                     end
                     S_READ: begin
                        if (!last_byte) begin
                           next_r.remaining = r.remaining - 8'h01;
                           next_r.sda_oe = 1'b0;
                           next_r.state = M_BIT_LO;
                        end else if (r.term == TERM_NACK_START) begin
                           next_r.state = M_RS_LO;
                           next_r.sda_oe = 1'b0;
                           next_r.end_after_start = 1'b1;
                        end
                        // otherwise nack then stop
                     end
                  endcase
               end
            end
         end
         M_RS_LO: begin
            if (tdone) begin
               next_r.scl = 1'b1;
               next_r.state = M_RS_HI;
            end
         end
         M_RS_HI: begin
            if (tdone) begin
               next_r.state = M_START;
               next_r.sda_oe = 1'b1; // repeated start
               next_r.stage = S_SLA_R;
               next_r.tx = {DEV_TYPE, r.page, RW_READ};
            end
         end
         M_STOP_LO: begin
            if (tdone) begin
               next_r.scl = 1'b1;
               next_r.state = M_STOP_HI;
            end
         end
         M_STOP_HI: begin
            if (tdone) begin
               next_r.sda_oe = 1'b0; // sda rises while scl is high
               next_r.end_after_start = 1'b0;
               next_r.state = M_BUS_FREE;
            end
         end
         M_BUS_FREE: begin
            if (tdone) begin
               next_r.state = M_IDLE;
            end
         end
         default: begin
            next_r = HOST_RESET;
         end
      endcase
      // two-entry read buffer
      if (push) begin
         next_r.buf_data[r.wp] = rx_full;
         next_r.wp = !r.wp;
      end
      if (pop) begin
         next_r.rp = !r.rp;
      end
      next_r.buf_cnt = r.buf_cnt + {1'b0, push} - {1'b0, pop};
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r <= HOST_RESET;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign link.scl = r.scl;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe = r.sda_oe;
   assign cmd_ready_o = (r.state == M_IDLE);
   assign rd_data_o = r.buf_data[r.rp];
   assign rd_valid_o = (r.buf_cnt != 2'h0);
   assign nack_o = r.nack;
   assign busy_o = (r.state != M_IDLE);

endmodule

// >>> rtl/mem_rd_pkg.sv
// Purpose: shared constants and types for the two-wire serial memory read path
// Assumes: one 40 MHz core clock on both ends; the host makes the serial clock
// Notes:   the device type code below is an arbitrary value, not a real part code
package mem_rd_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // timing: one bus phase covers the longest low, high, setup, hold and bus free minimum
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_PHASE_NS = 1300;
   localparam int PHASE_CYC_I = (T_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [5:0] PHASE_LAST = 6'(PHASE_CYC_I - 1);
   ////////////////////////////////////////////////////////////////////////////////
   // address space and slave address layout
   localparam int ADDR_W = 11;
   localparam int PAGE_W = 3;
   localparam int MEM_DEPTH = 2048;
   localparam logic [10:0] ADDR_MAX = 11'h7FF;
   localparam logic [10:0] ADDR_WRAP = 11'h000;
   localparam logic [10:0] ADDR_STEP = 11'h001;
   localparam logic [3:0] DEV_TYPE = 4'h5; // arbitrary value
   localparam logic RW_READ = 1'b1;
   localparam logic RW_WRITE = 1'b0;
   localparam logic [3:0] BIT_LAST = 4'h7; // last data bit of a byte
   localparam logic [3:0] BIT_ACK = 4'h8; // acknowledge slot, 9th clock
   localparam logic [3:0] BIT_ONE = 4'h1;
   ////////////////////////////////////////////////////////////////////////////////
   // how the host ends a read
   localparam logic [1:0] TERM_NACK_STOP = 2'h0;
   localparam logic [1:0] TERM_NACK_START = 2'h1;
   localparam logic [1:0] TERM_STOP = 2'h2;
   localparam logic [1:0] TERM_START = 2'h3;
   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      D_IDLE, D_SLA, D_SLA_ACK, D_WADDR, D_WADDR_ACK, D_WIGNORE, D_RD, D_RD_ACK
   } dev_state_t;
   typedef enum logic [3:0] {
      M_IDLE, M_START, M_BIT_LO, M_BIT_HI, M_RS_LO, M_RS_HI, M_STOP_LO, M_STOP_HI,
      M_BUS_FREE
   } host_state_t;
   typedef enum logic [1:0] {S_SLA_W, S_WADDR, S_SLA_R, S_READ} host_stage_t;
endpackage

// >>> rtl/two_wire_if.sv
// Purpose: the two-wire link between host and memory device
// Assumes: both ends only pull the data line low; high comes from the pull-up
// Notes:   the wired level is resolved here so design files need no tristate
`timescale 1ns/1ps
interface two_wire_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic sda;
   // wired-and of both open-drain drivers with an implied pull-up
   assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
   modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
   modport dev (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface
